// ### shared/hub_ctrl_pkg.sv
// Purpose: Shared constants and types for the hub function endpoint control block.
// Assumes: Registers are 8 bits wide, in the low byte of aligned 32-bit AXI4-Lite words.
// Notes:   The packet engine outside this block moves the bytes; here are only its events.
package hub_ctrl_pkg;

  localparam int          AXI_DW = 32;

  // Byte offsets of the register words.
  localparam logic [4:0]  OFS_ADDR_EN   = 5'h00;
  localparam logic [4:0]  OFS_EP0_FLAGS = 5'h04;
  localparam logic [4:0]  OFS_EP0_CTRL  = 5'h08;
  localparam logic [4:0]  OFS_EP1_CTRL  = 5'h0c;
  localparam logic [4:0]  OFS_EP0_STAT  = 5'h10;

  // Address and enable register.
  localparam int          B_MOD_EN      = 7;
  // Endpoint 0 interrupt flags register.
  localparam int          B_TX_FLAG     = 7;
  localparam int          B_RX_FLAG     = 6;
  localparam int          B_TX_IE       = 3;
  localparam int          B_RX_IE       = 2;
  localparam int          B_TX_CLR      = 1;
  localparam int          B_RX_CLR      = 0;
  // Endpoint 0 control register; bits 3:0 hold the transmit size.
  localparam int          B_TX_TOGGLE   = 7;
  localparam int          B_EP0_STALL   = 6;
  localparam int          B_TX_EN       = 5;
  localparam int          B_RX_EN       = 4;
  // Endpoint 1 register; bits 5:0 hold the change bitmap.
  localparam int          B_EP1_STALL   = 7;
  localparam int          B_REPORT_RDY  = 6;
  // Endpoint 0 status register; bits 3:0 hold the received size.
  localparam int          B_RX_TOGGLE   = 7;
  localparam int          B_SETUP_SEEN  = 6;
  localparam int          B_TX_FIRST    = 5;
  localparam int          B_TX_FIRST_CLR = 4;

  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [3:0]  EP0           = 4'h0;
  localparam logic [3:0]  EP1           = 4'h1;
  localparam logic [3:0]  EP1_REPORT_LEN = 4'h1;

  typedef enum logic [1:0] {
    TOK_OUT   = 2'h0,
    TOK_IN    = 2'h1,
    TOK_SETUP = 2'h2
  } token_kind_t;

  typedef enum logic [2:0] {
    ANS_NONE   = 3'h0,
    ANS_NAK    = 3'h1,
    ANS_STALL  = 3'h2,
    ANS_SEND   = 3'h3,
    ANS_ACCEPT = 3'h4
  } answer_kind_t;

  typedef struct packed {
    logic        valid;
    token_kind_t kind;
    logic [6:0]  addr;
    logic [3:0]  ep;
  } token_t;

  typedef struct packed {
    logic       valid;
    logic       data1;
    logic [3:0] count;
  } rx_done_t;

  typedef struct packed {
    logic         valid;
    answer_kind_t kind;
    logic         data1;
    logic [3:0]   size;
    logic [7:0]   payload;
  } answer_t;

endpackage : hub_ctrl_pkg

// ### rtl/hub_function_ctrl.sv
// Purpose: Hub function control: enable, address, endpoint 0 and endpoint 1 decisions.
// Assumes: A packet engine delivers decoded tokens and end-of-transfer events on aclk.
// Notes:   Overview of operation follows.
`timescale 1ns/1ps
module hub_function_ctrl
  import hub_ctrl_pkg::*;
#(
  parameter int AXI_AW = 5
)
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      por_n,
  input  wire logic [AXI_AW-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output      logic                      s_axi_awready,
  input  wire logic [hub_ctrl_pkg::AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output      logic                      s_axi_wready,
  output      logic [1:0]                s_axi_bresp,
  output      logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [AXI_AW-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output      logic                      s_axi_arready,
  output      logic [hub_ctrl_pkg::AXI_DW-1:0] s_axi_rdata,
  output      logic [1:0]                s_axi_rresp,
  output      logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire hub_ctrl_pkg::token_t      token,
  input  wire logic                      ep0_in_acked,
  input  wire hub_ctrl_pkg::rx_done_t    ep0_rx_done,
  output      hub_ctrl_pkg::answer_t     answer,
  output      logic                      regulated_output,
  output      logic                      transceiver_en,
  output      logic                      irq
);
  import hub_ctrl_pkg::*;

  // The register map needs five address bits; a narrower bus cannot reach the status word.
  if (AXI_AW < 5)
  begin : g_aw_check
    $error("AXI_AW must be at least 5");
  end

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  // Register index of a byte address; 3'h7 marks an unmapped address.
  function automatic logic [2:0] reg_index(input logic [AXI_AW-1:0] a);
    logic [4:0] ofs;
    ofs = a[4:0];
    if ((a >> 5) != '0 || a[1:0] != 2'h0)
    begin
      reg_index = 3'h7;
    end
    else
    begin
      case (ofs)
        OFS_ADDR_EN:   reg_index = 3'h0;
        OFS_EP0_FLAGS: reg_index = 3'h1;
        OFS_EP0_CTRL:  reg_index = 3'h2;
        OFS_EP1_CTRL:  reg_index = 3'h3;
        OFS_EP0_STAT:  reg_index = 3'h4;
        default:       reg_index = 3'h7;
      endcase
    end
  endfunction : reg_index

  wr_state_t             wr_state_q;
  logic                  have_aw_q;
  logic                  have_w_q;
  logic [AXI_AW-1:0]     awaddr_q;
  logic [7:0]            wbyte_q;
  logic                  wlane_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [AXI_DW-1:0]     rdata_q;
  logic [1:0]            rresp_q;

  logic                  mod_en_q;
  logic [6:0]            func_addr_q;
  logic                  tx_flag_q;
  logic                  rx_flag_q;
  logic                  tx_ie_q;
  logic                  rx_ie_q;
  logic                  tx_toggle_q;
  logic                  ep0_stall_q;
  logic                  tx_en_q;
  logic                  rx_en_q;
  logic [3:0]            tx_size_q;
  logic                  ep1_stall_q;
  logic                  report_rdy_q;
  logic [5:0]            change_bitmap_q;
  logic                  rx_toggle_q;
  logic                  setup_seen_q;
  logic                  tx_first_q;
  logic [3:0]            rx_size_q;
  answer_t               answer_q;

  // Write channel decode.
  wire        wr_do    = (wr_state_q == WR_IDLE) && have_aw_q && have_w_q;
  wire [2:0]  wr_idx   = reg_index(awaddr_q);
  wire        wr_hit   = wr_do && wlane_q;
  wire        wr_addr  = wr_hit && (wr_idx == 3'h0);
  wire        wr_flags = wr_hit && (wr_idx == 3'h1);
  wire        wr_ctrl0 = wr_hit && (wr_idx == 3'h2);
  wire        wr_ctrl1 = wr_hit && (wr_idx == 3'h3);
  wire        wr_stat  = wr_hit && (wr_idx == 3'h4);
  wire        aw_take  = s_axi_awvalid && s_axi_awready;
  wire        w_take   = s_axi_wvalid && s_axi_wready;

  assign s_axi_awready = (wr_state_q == WR_IDLE) && !have_aw_q;
  assign s_axi_wready  = (wr_state_q == WR_IDLE) && !have_w_q;
  assign s_axi_bvalid  = (wr_state_q == WR_RESP);
  assign s_axi_bresp   = bresp_q;

  // Address and data may come in either order; each is held until both are here.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state_q <= WR_IDLE;
      have_aw_q  <= 1'b0;
      have_w_q   <= 1'b0;
      awaddr_q   <= '0;
      wbyte_q    <= RST_BYTE;
      wlane_q    <= 1'b0;
      bresp_q    <= RESP_OKAY;
    end
    else
    begin
      case (wr_state_q)
        WR_IDLE:
        begin
          if (aw_take)
          begin
            have_aw_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
          end
          if (w_take)
          begin
            have_w_q <= 1'b1;
            wbyte_q  <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
          end
          if (wr_do)
          begin
            wr_state_q <= WR_RESP;
            bresp_q    <= (wr_idx == 3'h7) ? RESP_SLVERR : RESP_OKAY;
          end
        end
        WR_RESP:
        begin
          if (s_axi_bready)
          begin
            wr_state_q <= WR_IDLE;
            have_aw_q  <= 1'b0;
            have_w_q   <= 1'b0;
          end
        end
        default:
        begin
          wr_state_q <= WR_IDLE;
        end
      endcase
    end
  end

  // Read channel: one read at a time, data one cycle after the address is taken.
  wire        ar_take = s_axi_arvalid && s_axi_arready;
  wire [2:0]  rd_idx  = reg_index(s_axi_araddr);
  logic [7:0] rd_byte;

  always_comb
  begin
    case (rd_idx)
      3'h0:    rd_byte = {mod_en_q, func_addr_q};
      3'h1:    rd_byte = {tx_flag_q, rx_flag_q, 2'b00, tx_ie_q, rx_ie_q, 2'b00};
      3'h2:    rd_byte = {tx_toggle_q, ep0_stall_q, tx_en_q, rx_en_q, tx_size_q};
      3'h3:    rd_byte = {ep1_stall_q, report_rdy_q, change_bitmap_q};
      3'h4:    rd_byte = {rx_toggle_q, setup_seen_q, tx_first_q, 1'b0, rx_size_q};
      default: rd_byte = RST_BYTE;
    endcase
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {{(AXI_DW-8){1'b0}}, rd_byte};
      rresp_q  <= (rd_idx == 3'h7) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // Token decode toward the hub function.
  wire tok_hit   = token.valid && mod_en_q && (token.addr == func_addr_q);
  wire tok_ep0   = tok_hit && (token.ep == EP0);
  wire tok_ep1   = tok_hit && (token.ep == EP1);
  wire tok_setup = tok_ep0 && (token.kind == TOK_SETUP);
  wire in_busy   = !tx_en_q || tx_flag_q;
  wire out_busy  = !rx_en_q || rx_flag_q;
  wire tx_set    = mod_en_q && ep0_in_acked;
  wire rx_set    = mod_en_q && ep0_rx_done.valid;

  answer_t ans_d;

  always_comb
  begin
    ans_d = '0;
    ans_d.data1 = tx_toggle_q;
    if (tok_setup)
    begin
      ans_d.valid = 1'b1;
      ans_d.kind  = ANS_ACCEPT;
    end
    else if (tok_ep0)
    begin
      ans_d.valid = 1'b1;
      if (ep0_stall_q)
      begin
        ans_d.kind = ANS_STALL;
      end
      else if (token.kind == TOK_IN)
      begin
        ans_d.kind = in_busy ? ANS_NAK : ANS_SEND;
        ans_d.size = tx_size_q;
      end
      else
      begin
        ans_d.kind = out_busy ? ANS_NAK : ANS_ACCEPT;
      end
    end
    else if (tok_ep1)
    begin
      ans_d.valid = 1'b1;
      if (ep1_stall_q || token.kind != TOK_IN)
      begin
        ans_d.kind = ANS_STALL;
      end
      else if (!report_rdy_q)
      begin
        ans_d.kind = ANS_NAK;
      end
      else
      begin
        ans_d.kind    = ANS_SEND;
        ans_d.size    = EP1_REPORT_LEN;
        ans_d.payload = {2'b00, change_bitmap_q};
      end
    end
    else
    begin
      ans_d.data1 = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      answer_q <= '0;
    end
    else
    begin
      answer_q <= ans_d;
    end
  end

  assign answer = answer_q;

  // Module enable: set by software, cleared only at power-on.
  always_ff @(posedge aclk)
  begin
    if (!por_n)
    begin
      mod_en_q <= 1'b0;
    end
    else if (wr_addr && wbyte_q[B_MOD_EN])
    begin
      mod_en_q <= 1'b1;
    end
  end

  assign regulated_output = mod_en_q;
  assign transceiver_en   = mod_en_q;

  // Flags: a hardware set in the same cycle as a software clear wins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      func_addr_q <= '0;
      tx_flag_q   <= 1'b0;
      rx_flag_q   <= 1'b0;
      tx_ie_q     <= 1'b0;
      rx_ie_q     <= 1'b0;
      tx_first_q  <= 1'b0;
    end
    else
    begin
      if (wr_addr)
      begin
        func_addr_q <= wbyte_q[6:0];
      end
      if (wr_flags)
      begin
        tx_ie_q <= wbyte_q[B_TX_IE];
        rx_ie_q <= wbyte_q[B_RX_IE];
      end
      if (tx_set)
      begin
        tx_flag_q <= 1'b1;
      end
      else if (wr_flags && wbyte_q[B_TX_CLR])
      begin
        tx_flag_q <= 1'b0;
      end
      if (rx_set)
      begin
        rx_flag_q <= 1'b1;
      end
      else if (wr_flags && wbyte_q[B_RX_CLR])
      begin
        rx_flag_q <= 1'b0;
      end
      if (rx_set && tx_flag_q)
      begin
        tx_first_q <= 1'b1;
      end
      else if (wr_stat && wbyte_q[B_TX_FIRST_CLR])
      begin
        tx_first_q <= 1'b0;
      end
    end
  end

  // Control registers of both endpoints.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_toggle_q     <= 1'b0;
      ep0_stall_q     <= 1'b0;
      tx_en_q         <= 1'b0;
      rx_en_q         <= 1'b0;
      tx_size_q       <= '0;
      ep1_stall_q     <= 1'b0;
      report_rdy_q    <= 1'b0;
      change_bitmap_q <= '0;
    end
    else
    begin
      if (wr_ctrl0)
      begin
        tx_toggle_q <= wbyte_q[B_TX_TOGGLE];
        ep0_stall_q <= wbyte_q[B_EP0_STALL];
        tx_en_q     <= wbyte_q[B_TX_EN];
        rx_en_q     <= wbyte_q[B_RX_EN];
        tx_size_q   <= wbyte_q[3:0];
      end
      // A SETUP clears the stall even against a software write in the same cycle.
      if (tok_setup)
      begin
        ep0_stall_q <= 1'b0;
      end
      if (wr_ctrl1)
      begin
        ep1_stall_q     <= wbyte_q[B_EP1_STALL];
        report_rdy_q    <= wbyte_q[B_REPORT_RDY];
        change_bitmap_q <= wbyte_q[5:0];
      end
    end
  end

  // Reception status; the received size deliberately survives reset.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_toggle_q  <= 1'b0;
      setup_seen_q <= 1'b0;
    end
    else
    begin
      if (rx_set)
      begin
        rx_toggle_q <= ep0_rx_done.data1;
      end
      if (tok_ep0)
      begin
        setup_seen_q <= tok_setup;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (rx_set)
    begin
      rx_size_q <= ep0_rx_done.count;
    end
  end

  assign irq = (tx_flag_q && tx_ie_q) || (rx_flag_q && rx_ie_q);

endmodule : hub_function_ctrl

// ### verif/hub_ctrl_sva.sv
// Purpose: Port-level checks for the hub function control block.
// Assumes: One aclk domain; answer is a one-cycle pulse after the token edge.
// Notes:   Module enable is visible through both regulated_output and transceiver_en.
`timescale 1ns/1ps
module hub_ctrl_sva
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  por_n,
  input wire hub_ctrl_pkg::token_t  token,
  input wire hub_ctrl_pkg::answer_t answer,
  input wire logic                  regulated_output,
  input wire logic                  transceiver_en,
  input wire logic                  irq
);
  import hub_ctrl_pkg::*;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_off_silent;
    !regulated_output && token.valid |=> !answer.valid;
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("answer while disabled");

  property p_pair;
    regulated_output == transceiver_en;
  endproperty
  a_pair: assert property (p_pair) else $error("regulator and transceiver differ");

  // Ordinary reset must not drop the enable, so only power-on reset disables this check.
  property p_en_keep;
    disable iff (!por_n) regulated_output |=> regulated_output;
  endproperty
  a_en_keep: assert property (p_en_keep) else $error("enable lost without power-on");

  property p_cause;
    answer.valid |-> $past(token.valid);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without token");

  property p_in_kind;
    answer.valid && $past(token.ep) == EP0 && $past(token.kind) == TOK_IN
      |-> answer.kind inside {ANS_NAK, ANS_STALL, ANS_SEND};
  endproperty
  a_in_kind: assert property (p_in_kind) else $error("bad answer to IN");

  property p_out_kind;
    answer.valid && $past(token.ep) == EP0 && $past(token.kind) == TOK_OUT
      |-> answer.kind inside {ANS_NAK, ANS_STALL, ANS_ACCEPT};
  endproperty
  a_out_kind: assert property (p_out_kind) else $error("bad answer to OUT");

  property p_setup;
    answer.valid && $past(token.ep) == EP0 && $past(token.kind) == TOK_SETUP
      |-> answer.kind == ANS_ACCEPT;
  endproperty
  a_setup: assert property (p_setup) else $error("setup not accepted");

  property p_ep1_stall;
    answer.valid && $past(token.ep) == EP1 && $past(token.kind) != TOK_IN
      |-> answer.kind == ANS_STALL;
  endproperty
  a_ep1_stall: assert property (p_ep1_stall) else $error("ep1 non-IN not stalled");

  property p_ep1_report;
    answer.valid && answer.kind == ANS_SEND && $past(token.ep) == EP1
      |-> answer.size == EP1_REPORT_LEN && answer.payload[7:6] == 2'h0;
  endproperty
  a_ep1_report: assert property (p_ep1_report) else $error("bad ep1 report");

  property p_irq_reset;
    $rose(aresetn) |-> !irq;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("irq high after reset");
endmodule : hub_ctrl_sva

// ### verif/upstream_host_model.sv
// Purpose: Upstream host stand-in issuing tokens and transfer-end events.
// Assumes: Every event is a one-cycle pulse launched just after a rising edge.
// Notes:   Released token fields are inverted so a stale value never looks current.
`timescale 1ns/1ps
module upstream_host_model
(
  input  wire logic              aclk,
  output hub_ctrl_pkg::token_t   token,
  output logic                   ep0_in_acked,
  output hub_ctrl_pkg::rx_done_t ep0_rx_done
);
  import hub_ctrl_pkg::*;

  initial
  begin
    token        = '0;
    ep0_in_acked = 1'b0;
    ep0_rx_done  = '0;
  end

  task automatic poll(input token_kind_t k, input logic [6:0] a, input logic [3:0] e);
    @(posedge aclk);
    token <= {1'b1, k, a, e};
    @(posedge aclk);
    token <= {1'b0, ~k, ~a, ~e};
  endtask : poll

  task automatic ack_in();
    @(posedge aclk);
    ep0_in_acked <= 1'b1;
    @(posedge aclk);
    ep0_in_acked <= 1'b0;
  endtask : ack_in

  task automatic rx_end(input logic d1, input logic [3:0] n);
    @(posedge aclk);
    ep0_rx_done <= {1'b1, d1, n};
    @(posedge aclk);
    ep0_rx_done <= {1'b0, ~d1, ~n};
  endtask : rx_end
endmodule : upstream_host_model

// ### verif/tb_usb_hub_function_endpoint_ctrl.sv
// Purpose: Self-checking bench for the hub function control block.
// Assumes: AXI4-Lite master and host model drive just after rising edges.
// Notes:   Function address 05 is used throughout, except one poll to address 06.
`timescale 1ns/1ps
module tb_usb_hub_function_endpoint_ctrl;
  import hub_ctrl_pkg::*;

  localparam logic [6:0] FN_ADDR = 7'h05;

  logic aclk, aresetn, por_n, regulated_output, transceiver_en, irq;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  token_t   token;
  rx_done_t ep0_rx_done;
  answer_t  answer;
  logic     ep0_in_acked;
  int       mismatches = 0;
  int       tests_run = 0;
  int       cycles = 0;

  hub_function_ctrl dut
  (
    .aclk, .aresetn, .por_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .token, .ep0_in_acked, .ep0_rx_done, .answer,
    .regulated_output, .transceiver_en, .irq
  );

  upstream_host_model host (.aclk, .token, .ep0_in_acked, .ep0_rx_done);

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rst(input logic p);
    @(posedge aclk);
    aresetn <= 1'b0;
    por_n   <= ~p;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    por_n   <= 1'b1;
  endtask : rst

  // Offsets above the status word are unmapped and must answer with an error.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        s_axi_bready <= 1'b0;
        chk("bresp", (a > OFS_EP0_STAT) ? RESP_SLVERR : RESP_OKAY, {30'h0, s_axi_bresp});
        break;
      end
    end
  endtask : wr

  task automatic rd(input string n, input logic [4:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hff);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        s_axi_rready <= 1'b0;
        chk(n, {24'h0, e}, s_axi_rdata & {24'hffffff, m});
        chk("rresp", (a > OFS_EP0_STAT) ? RESP_SLVERR : RESP_OKAY, {30'h0, s_axi_rresp});
        break;
      end
    end
  endtask : rd

  task automatic tk(input token_kind_t k, input logic [3:0] e, input answer_kind_t x,
                    input logic [3:0] sz = 4'h0, input logic d1 = 1'b0);
    host.poll(k, FN_ADDR, e);
    #1;
    chk("ans_valid", {31'h0, x != ANS_NONE}, {31'h0, answer.valid});
    if (x != ANS_NONE)
      chk("ans_kind", {29'h0, x}, {29'h0, answer.kind});
    if (x == ANS_SEND)
      chk("ans_size_seq", {27'h0, sz, d1}, {27'h0, answer.size, answer.data1});
  endtask : tk

  initial
  begin
    {aresetn, por_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    rst(1'b1);
    rd("addr_en", OFS_ADDR_EN, 8'h00);
    rd("flags", OFS_EP0_FLAGS, 8'h00);
    rd("ctrl", OFS_EP0_CTRL, 8'h00);
    rd("ep1", OFS_EP1_CTRL, 8'h00);
    rd("status", OFS_EP0_STAT, 8'h00, 8'hf0);
    rd("unmapped", 5'h14, 8'h00);
    wr(5'h14, 8'hff);
    chk("regulated", 32'h0, {31'h0, regulated_output});
    wr(OFS_ADDR_EN, 8'h05);
    tk(TOK_IN, EP0, ANS_NONE);
    host.ack_in();
    rd("flags", OFS_EP0_FLAGS, 8'h00);
    $display("test reset_and_disabled done");
    wr(OFS_ADDR_EN, 8'h85);
    chk("xcvr", 32'h1, {31'h0, transceiver_en});
    rd("addr_en", OFS_ADDR_EN, 8'h85);
    s_axi_wstrb <= 4'he;
    wr(OFS_ADDR_EN, 8'h00);
    s_axi_wstrb <= 4'hf;
    rd("addr_en", OFS_ADDR_EN, 8'h85);
    host.poll(TOK_IN, 7'h06, EP0);
    #1 chk("ans_valid", 32'h0, {31'h0, answer.valid});
    tk(TOK_IN, EP0, ANS_NAK);
    wr(OFS_ADDR_EN, 8'h05);
    rd("addr_en", OFS_ADDR_EN, 8'h85);
    rst(1'b0);
    rd("addr_en", OFS_ADDR_EN, 8'h80);
    wr(OFS_ADDR_EN, 8'h85);
    $display("test enable_address done");
    wr(OFS_EP0_CTRL, 8'haf);
    tk(TOK_IN, EP0, ANS_SEND, 4'hf, 1'b1);
    host.ack_in();
    rd("flags", OFS_EP0_FLAGS, 8'h80);
    tk(TOK_IN, EP0, ANS_NAK);
    rd("ctrl", OFS_EP0_CTRL, 8'haf);
    wr(OFS_EP0_FLAGS, 8'hc0);
    rd("flags", OFS_EP0_FLAGS, 8'h80);
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFS_EP0_FLAGS, 8'h08);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFS_EP0_FLAGS, 8'h0a);
    chk("irq", 32'h0, {31'h0, irq});
    rd("flags", OFS_EP0_FLAGS, 8'h08);
    wr(OFS_EP0_CTRL, 8'h23);
    tk(TOK_IN, EP0, ANS_SEND, 4'h3, 1'b0);
    host.ack_in();
    rd("flags", OFS_EP0_FLAGS, 8'h88);
    chk("irq", 32'h1, {31'h0, irq});
    $display("test ep0_transmit done");
    tk(TOK_OUT, EP0, ANS_NAK);
    wr(OFS_EP0_CTRL, 8'h33);
    tk(TOK_OUT, EP0, ANS_ACCEPT);
    host.rx_end(1'b1, 4'h9);
    rd("flags", OFS_EP0_FLAGS, 8'hc8);
    rd("status", OFS_EP0_STAT, 8'ha9);
    tk(TOK_OUT, EP0, ANS_NAK);
    wr(OFS_EP0_STAT, 8'h00);
    rd("status", OFS_EP0_STAT, 8'ha9);
    wr(OFS_EP0_STAT, 8'h10);
    rd("status", OFS_EP0_STAT, 8'h89);
    wr(OFS_EP0_FLAGS, 8'h04);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFS_EP0_FLAGS, 8'h07);
    rd("flags", OFS_EP0_FLAGS, 8'h04);
    chk("irq", 32'h0, {31'h0, irq});
    rst(1'b0);
    rd("status", OFS_EP0_STAT, 8'h09);
    wr(OFS_ADDR_EN, 8'h85);
    $display("test ep0_receive done");
    wr(OFS_EP0_CTRL, 8'h70);
    tk(TOK_IN, EP0, ANS_STALL);
    tk(TOK_OUT, EP0, ANS_STALL);
    tk(TOK_SETUP, EP0, ANS_ACCEPT);
    rd("ctrl", OFS_EP0_CTRL, 8'h30);
    host.rx_end(1'b0, 4'h8);
    rd("status", OFS_EP0_STAT, 8'h48);
    tk(TOK_OUT, EP0, ANS_NAK);
    rd("status", OFS_EP0_STAT, 8'h08);
    $display("test ep0_stall_setup done");
    tk(TOK_IN, EP1, ANS_NAK);
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_EP1_CTRL, 8'h40 | (8'h01 << i));
      tk(TOK_IN, EP1, ANS_SEND, EP1_REPORT_LEN);
      chk("payload", {24'h0, 8'h01 << i}, {24'h0, answer.payload});
    end
    wr(OFS_EP1_CTRL, 8'hff);
    rd("ep1", OFS_EP1_CTRL, 8'hff);
    tk(TOK_IN, EP1, ANS_STALL);
    tk(TOK_OUT, EP1, ANS_STALL);
    tk(TOK_IN, 4'h2, ANS_NONE);
    $display("test ep1 done");
    rst(1'b1);
    chk("regulated", 32'h0, {31'h0, regulated_output});
    wr(OFS_ADDR_EN, 8'h05);
    tk(TOK_SETUP, EP0, ANS_NONE);
    host.ack_in();
    rd("flags", OFS_EP0_FLAGS, 8'h00);
    $display("test power_on done");
    report_and_stop();
  end
endmodule : tb_usb_hub_function_endpoint_ctrl

bind hub_function_ctrl hub_ctrl_sva u_sva
(
  .aclk(aclk), .aresetn(aresetn), .por_n(por_n), .token(token), .answer(answer),
  .regulated_output(regulated_output), .transceiver_en(transceiver_en), .irq(irq)
);
